// >>> shared/dtc_pkg.sv
// Constants and types shared by the dual timer/counter pair.
package dtc_pkg;
   // Register offsets; the count byte offsets sit beside the two control registers.
   localparam logic [7:0] CTRL_OFFSET = 8'h88;
   localparam logic [7:0] MODE_OFFSET = 8'h89;
   localparam logic [7:0] LOW_A_OFFSET = 8'h8A;
   localparam logic [7:0] LOW_B_OFFSET = 8'h8B;
   localparam logic [7:0] HIGH_A_OFFSET = 8'h8C;
   localparam logic [7:0] HIGH_B_OFFSET = 8'h8D;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   // Control register bit positions.
   localparam int OVF_B_BIT = 7;
   localparam int RUN_B_BIT = 6;
   localparam int OVF_A_BIT = 5;
   localparam int RUN_A_BIT = 4;
   localparam int EXT_FLAG_B_BIT = 3;
   localparam int EXT_TYPE_B_BIT = 2;
   localparam int EXT_FLAG_A_BIT = 1;
   localparam int EXT_TYPE_A_BIT = 0;
   // Mode register bit positions.
   localparam int GATE_B_BIT = 7;
   localparam int FUNC_B_BIT = 6;
   localparam int MODE_B_LSB = 4;
   localparam int GATE_A_BIT = 3;
   localparam int FUNC_A_BIT = 2;
   localparam int MODE_A_LSB = 0;
   // Mode select encodings.
   localparam logic [1:0] MODE_PRESCALED = 2'h0;
   localparam logic [1:0] MODE_FULL16 = 2'h1;
   localparam logic [1:0] MODE_RELOAD8 = 2'h2;
   localparam logic [1:0] MODE_SPLIT = 2'h3;
   // sys_clk is the oscillator; a machine cycle is a fixed count of its periods.
   localparam int OSC_PERIOD_NS = 50;
   localparam int MACHINE_CYCLE_OSC_PERIODS = 6;
   localparam int MACHINE_CYCLE_NS = MACHINE_CYCLE_OSC_PERIODS * OSC_PERIOD_NS;
   localparam int MACHINE_CYCLE_CLKS = MACHINE_CYCLE_NS / OSC_PERIOD_NS;
   localparam logic [2:0] MC_LAST = 3'(MACHINE_CYCLE_CLKS - 1);
   localparam logic [4:0] PRESCALE_MAX = 5'h1F;
   localparam logic [7:0] BYTE_MAX = 8'hFF;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wrData;
      logic wrStb;
      logic rdStb;
      logic bitWrStb;
      logic [2:0] bitIdx;
      logic bitVal;
   } dtc_req_s;
endpackage : dtc_pkg

// >>> src/dtc_pin_sampler.sv
// Pin synchroniser with once-per-machine-cycle sampling and falling edge detect.
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_sampler (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic mcTick,
   input wire logic pinIn,
   output logic level,
   output logic fall
);
   import dtc_pkg::*;
   logic sync1_reg;
   logic sync2_reg;
   logic sample_reg;
   logic prev_reg;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
      end else if (clkEn) begin
         sync1_reg <= pinIn;
         sync2_reg <= sync1_reg;
      end
   end

   // The pin is looked at only once per machine cycle.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sample_reg <= 1'b1;
         prev_reg <= 1'b1;
      end else if (clkEn && mcTick) begin
         sample_reg <= sync2_reg;
         prev_reg <= sample_reg;
      end
   end

   assign level = sample_reg;
   // High in one sample and low in the next marks one edge.
   assign fall = mcTick & prev_reg & ~sample_reg;
endmodule : dtc_pin_sampler
`default_nettype wire

// >>> src/dtc_timer_pair.sv
// Two 16-bit timer/counter units with mode and control registers.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_pair (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire dtc_pkg::dtc_req_s regReq,
   output logic [7:0] rdData,
   input wire logic countPinA,
   input wire logic countPinB,
   input wire logic extIrqPinA,
   input wire logic extIrqPinB,
   input wire logic ovfAckA,
   input wire logic ovfAckB,
   input wire logic extAckA,
   input wire logic extAckB,
   output logic ovfFlagA,
   output logic ovfFlagB,
   output logic extFlagA,
   output logic extFlagB
);
   import dtc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Elaboration checks. The logic hard-wires a three-bit divider, byte-wide register fields
   // and one six-byte register window. Package values that break these are refused here
   // rather than left to show up later as a quietly wrong count.
   if (MACHINE_CYCLE_CLKS < 2 || MACHINE_CYCLE_CLKS > 8) begin : gDividerFit
      $error("The machine cycle length does not fit the three-bit divider.");
   end
   if (PRESCALE_MAX != 5'h1F || BYTE_MAX != 8'hFF) begin : gWrapFit
      $error("Prescaler and byte limits must be the all-ones values of their fields.");
   end
   if (((1 << OVF_B_BIT) | (1 << RUN_B_BIT) | (1 << OVF_A_BIT) | (1 << RUN_A_BIT) |
        (1 << EXT_FLAG_B_BIT) | (1 << EXT_TYPE_B_BIT) | (1 << EXT_FLAG_A_BIT) |
        (1 << EXT_TYPE_A_BIT)) != 255) begin : gCtrlFields
      $error("Control bit positions must be distinct and fill one byte.");
   end
   if (((3 << MODE_B_LSB) | (1 << GATE_B_BIT) | (1 << FUNC_B_BIT) | (3 << MODE_A_LSB) |
        (1 << GATE_A_BIT) | (1 << FUNC_A_BIT)) != 255) begin : gModeFields
      $error("Mode field positions must be distinct and fill one byte.");
   end
   if (MODE_OFFSET != CTRL_OFFSET + 8'h01 || LOW_A_OFFSET != CTRL_OFFSET + 8'h02 ||
       LOW_B_OFFSET != CTRL_OFFSET + 8'h03 || HIGH_A_OFFSET != CTRL_OFFSET + 8'h04 ||
       HIGH_B_OFFSET != CTRL_OFFSET + 8'h05) begin : gRegWindow
      $error("Register offsets must form one window of six consecutive bytes.");
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   logic [2:0] mcCnt_reg;
   logic mcTick;
   logic cntFallA, cntFallB;
   logic irqLevelA, irqFallA, irqLevelB, irqFallB;
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic [7:0] mode_reg;
   logic [15:0] countA_reg;
   logic [15:0] countB_reg;
   logic [7:0] rdData_reg;
   logic [1:0] modeA, modeB;
   logic runA, runB, enA, enB, incA, incB, incHighA;
   logic [16:0] stepA, stepB;
   logic [8:0] splitHighA;
   logic ovfSetA, ovfSetB, extSetA, extSetB;
   logic wrCtrl, wrMode, wrLowA, wrLowB, wrHighA, wrHighB;

   // Steps a count by one in modes 0 to 2; bit 16 is the overflow.
   function automatic logic [16:0] countStep(input logic [15:0] c, input logic [1:0] m);
      logic [16:0] r;
      r = {1'b0, c};
      case (m)
         MODE_PRESCALED: begin
            // Only the low five bits prescale; bits 7:5 are left alone.
            r[4:0] = c[4:0] + 5'h01;
            if (c[4:0] == PRESCALE_MAX) begin
               r[15:8] = c[15:8] + 8'h01;
               r[16] = (c[15:8] == BYTE_MAX);
            end
         end
         MODE_FULL16: begin
            r = {1'b0, c} + 17'h00001;
         end
         MODE_RELOAD8: begin
            if (c[7:0] == BYTE_MAX) begin
               r = {1'b1, c[15:8], c[15:8]};
            end else begin
               r[7:0] = c[7:0] + 8'h01;
            end
         end
         // Mode three never steps here: unit B holds, and unit A's halves are handled apart.
         default: begin
            r = {1'b0, c};
         end
      endcase
      return r;
   endfunction : countStep

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Machine cycle divider.
   // Dropping clkEn mid-cycle stretches that machine cycle; no tick is lost or doubled.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mcCnt_reg <= 3'h0;
      end else if (clkEn) begin
         mcCnt_reg <= (mcCnt_reg == MC_LAST) ? 3'h0 : mcCnt_reg + 3'h1;
      end
   end
   assign mcTick = (mcCnt_reg == MC_LAST);

   // Pins are sampled once per machine cycle; a source must hold each level that long.
   // Only the edges of the count pins matter, so their levels are left unconnected.
   dtc_pin_sampler uCntA (
      .sys_clk(sys_clk),
      .rst(rst),
      .clkEn(clkEn),
      .mcTick(mcTick),
      .pinIn(countPinA),
      .level(),
      .fall(cntFallA)
   );
   dtc_pin_sampler uCntB (
      .sys_clk(sys_clk),
      .rst(rst),
      .clkEn(clkEn),
      .mcTick(mcTick),
      .pinIn(countPinB),
      .level(),
      .fall(cntFallB)
   );
   dtc_pin_sampler uIrqA (
      .sys_clk(sys_clk),
      .rst(rst),
      .clkEn(clkEn),
      .mcTick(mcTick),
      .pinIn(extIrqPinA),
      .level(irqLevelA),
      .fall(irqFallA)
   );
   dtc_pin_sampler uIrqB (
      .sys_clk(sys_clk),
      .rst(rst),
      .clkEn(clkEn),
      .mcTick(mcTick),
      .pinIn(extIrqPinB),
      .level(irqLevelB),
      .fall(irqFallB)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Count enables.
   // The gate reads the irq level sampled once per machine cycle, so gating takes hold up to
   // one machine cycle and two sys_clk periods after the pin moves.
   assign modeA = mode_reg[MODE_A_LSB +: 2];
   assign modeB = mode_reg[MODE_B_LSB +: 2];
   assign runA = ctrl_reg[RUN_A_BIT];
   assign runB = ctrl_reg[RUN_B_BIT];
   assign enA = runA & (~mode_reg[GATE_A_BIT] | irqLevelA);
   assign enB = runB & (~mode_reg[GATE_B_BIT] | irqLevelB) & (modeB != MODE_SPLIT);

   // A falling edge needs two samples, so pin counting peaks at one per two machine cycles.
   assign incA = enA & (mode_reg[FUNC_A_BIT] ? cntFallA : mcTick);
   assign incB = enB & (mode_reg[FUNC_B_BIT] ? cntFallB : mcTick);
   // In split mode the high byte of A is a plain machine-cycle timer owned by B's run bit.
   assign incHighA = (modeA == MODE_SPLIT) & runB & mcTick;

   assign stepA = countStep(countA_reg, modeA);
   assign stepB = countStep(countB_reg, modeB);
   assign splitHighA = {1'b0, countA_reg[15:8]} + 9'h001;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Register access decode.
   // Counts are read byte by byte with no latch, so a carry between the two reads can tear
   // the 16-bit value; software should stop the unit or read twice.
   assign wrCtrl = regReq.wrStb & (regReq.addr == CTRL_OFFSET);
   assign wrMode = regReq.wrStb & (regReq.addr == MODE_OFFSET);
   assign wrLowA = regReq.wrStb & (regReq.addr == LOW_A_OFFSET);
   assign wrLowB = regReq.wrStb & (regReq.addr == LOW_B_OFFSET);
   assign wrHighA = regReq.wrStb & (regReq.addr == HIGH_A_OFFSET);
   assign wrHighB = regReq.wrStb & (regReq.addr == HIGH_B_OFFSET);

   // A software write lands the byte; a count step in the same cycle is lost in that byte only.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         countA_reg <= COUNT_RESET;
      end else if (clkEn) begin
         if (modeA == MODE_SPLIT) begin
            if (incA) begin
               countA_reg[7:0] <= countA_reg[7:0] + 8'h01;
            end
            if (incHighA) begin
               countA_reg[15:8] <= splitHighA[7:0];
            end
         end else if (incA) begin
            countA_reg <= stepA[15:0];
         end
         if (wrLowA) begin
            countA_reg[7:0] <= regReq.wrData;
         end
         if (wrHighA) begin
            countA_reg[15:8] <= regReq.wrData;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         countB_reg <= COUNT_RESET;
      end else if (clkEn) begin
         if (incB) begin
            countB_reg <= stepB[15:0];
         end
         if (wrLowB) begin
            countB_reg[7:0] <= regReq.wrData;
         end
         if (wrHighB) begin
            countB_reg[15:8] <= regReq.wrData;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Flag set terms.
   always_comb begin
      if (modeA == MODE_SPLIT) begin
         ovfSetA = incA & (countA_reg[7:0] == BYTE_MAX);
      end else begin
         ovfSetA = incA & stepA[16];
      end
   end
   // Unit B keeps running in split mode but its overflow no longer reaches its flag.
   assign ovfSetB = (modeA == MODE_SPLIT) ? (incHighA & splitHighA[8])
                                          : (incB & stepB[16]);
   // In level mode the flag is set again in every cycle the sampled pin stays low, so an
   // acknowledge only sticks once the pin has gone high.
   assign extSetA = ctrl_reg[EXT_TYPE_A_BIT] ? irqFallA : ~irqLevelA;
   assign extSetB = ctrl_reg[EXT_TYPE_B_BIT] ? irqFallB : ~irqLevelB;

   // Software writes first, then acknowledges clear, then hardware sets win over both.
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wrCtrl) begin
         ctrl_next = regReq.wrData;
      end
      if (regReq.bitWrStb && (regReq.addr == CTRL_OFFSET)) begin
         ctrl_next[regReq.bitIdx] = regReq.bitVal;
      end
      if (ovfAckA) begin
         ctrl_next[OVF_A_BIT] = 1'b0;
      end
      if (ovfAckB) begin
         ctrl_next[OVF_B_BIT] = 1'b0;
      end
      if (extAckA) begin
         ctrl_next[EXT_FLAG_A_BIT] = 1'b0;
      end
      if (extAckB) begin
         ctrl_next[EXT_FLAG_B_BIT] = 1'b0;
      end
      if (ovfSetA) begin
         ctrl_next[OVF_A_BIT] = 1'b1;
      end
      if (ovfSetB) begin
         ctrl_next[OVF_B_BIT] = 1'b1;
      end
      if (extSetA) begin
         ctrl_next[EXT_FLAG_A_BIT] = 1'b1;
      end
      if (extSetB) begin
         ctrl_next[EXT_FLAG_B_BIT] = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrl_reg <= CTRL_RESET;
      end else if (clkEn) begin
         ctrl_reg <= ctrl_next;
      end
   end

   // The mode register takes whole-byte writes only; bit writes to it are ignored.
   // A mode change acts from the next edge and leaves the count bytes as they are.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mode_reg <= MODE_RESET;
      end else if (clkEn && wrMode) begin
         mode_reg <= regReq.wrData;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Read port: data stands the cycle after the strobe, zero elsewhere and when unmapped.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdData_reg <= 8'h00;
      end else if (clkEn) begin
         rdData_reg <= 8'h00;
         if (regReq.rdStb) begin
            case (regReq.addr)
               CTRL_OFFSET: rdData_reg <= ctrl_reg;
               MODE_OFFSET: rdData_reg <= mode_reg;
               LOW_A_OFFSET: rdData_reg <= countA_reg[7:0];
               LOW_B_OFFSET: rdData_reg <= countB_reg[7:0];
               HIGH_A_OFFSET: rdData_reg <= countA_reg[15:8];
               HIGH_B_OFFSET: rdData_reg <= countB_reg[15:8];
               default: rdData_reg <= 8'h00;
            endcase
         end
      end
   end

   assign rdData = rdData_reg;
   assign ovfFlagA = ctrl_reg[OVF_A_BIT];
   assign ovfFlagB = ctrl_reg[OVF_B_BIT];
   assign extFlagA = ctrl_reg[EXT_FLAG_A_BIT];
   assign extFlagB = ctrl_reg[EXT_FLAG_B_BIT];
endmodule : dtc_timer_pair
`default_nettype wire

// >>> verif/dtc_timer_pair_props.sv
// Concurrent checks on the ports of the timer/counter pair.
`timescale 1ns/1ps
`default_nettype none
module dtc_timer_pair_props
   import dtc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clkEn,
   input wire dtc_pkg::dtc_req_s regReq,
   input wire logic [7:0] rdData,
   input wire logic extIrqPinA,
   input wire logic ovfAckA,
   input wire logic extAckA,
   input wire logic ovfFlagA,
   input wire logic ovfFlagB,
   input wire logic extFlagA,
   input wire logic extFlagB
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   logic ctrlWr, bitWr, mapped, rdCtrl;
   logic [7:0] modeSh, ctrlSh;
   assign ctrlWr = clkEn && regReq.wrStb && regReq.addr == CTRL_OFFSET;
   assign bitWr = clkEn && regReq.bitWrStb && regReq.addr == CTRL_OFFSET;
   assign mapped = regReq.addr >= CTRL_OFFSET && regReq.addr <= HIGH_B_OFFSET;
   assign rdCtrl = clkEn && regReq.rdStb && regReq.addr == CTRL_OFFSET;
   // Shadows see only software writes, so flag bits in ctrlSh are never compared.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         modeSh <= MODE_RESET;
      end else if (clkEn && regReq.wrStb && regReq.addr == MODE_OFFSET) begin
         modeSh <= regReq.wrData;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrlSh <= CTRL_RESET;
      end else if (ctrlWr) begin
         ctrlSh <= regReq.wrData;
      end else if (bitWr) begin
         ctrlSh[regReq.bitIdx] <= regReq.bitVal;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   chk_rd_idle_zero: assert property (
      $past(clkEn) && !$past(clkEn && regReq.rdStb && mapped) |-> rdData == 8'h00)
      else $error("read data not zero outside a read");
   chk_mode_readback: assert property (
      clkEn && regReq.rdStb && regReq.addr == MODE_OFFSET |=> rdData == $past(modeSh))
      else $error("mode register read differs from bytes written");
   chk_ctrl_readback: assert property (
      rdCtrl |=> (rdData & 8'h55) == ($past(ctrlSh) & 8'h55))
      else $error("run or type bits read wrong");
   chk_flag_readback: assert property (
      rdCtrl |=> {rdData[7], rdData[5], rdData[3], rdData[1]}
         == $past({ovfFlagB, ovfFlagA, extFlagB, extFlagA}))
      else $error("flag bits in control read differ from flag outputs");
   chk_ovf_clear_cause: assert property (
      $fell(ovfFlagA) |-> $past(ovfAckA || ctrlWr || bitWr || rst))
      else $error("overflow flag A cleared without a cause");
   chk_ext_clear_cause: assert property (
      $fell(extFlagA) |-> $past(extAckA || ctrlWr || bitWr || rst))
      else $error("external flag A cleared without a cause");
   chk_level_sets_flag: assert property (
      (clkEn && !extIrqPinA && !ctrlSh[EXT_TYPE_A_BIT]) [*8] |-> ##[0:7] extFlagA)
      else $error("low level on irq pin A did not set its flag");
   chk_reset_clears: assert property (
      $fell(rst) && $past(clkEn) |->
         !(ovfFlagA || ovfFlagB || extFlagA || extFlagB) && rdData == 8'h00)
      else $error("flags or read data not zero after reset");
endmodule : dtc_timer_pair_props
bind dtc_timer_pair dtc_timer_pair_props dtc_timer_pair_props_inst (.sys_clk(sys_clk),
   .rst(rst), .clkEn(clkEn), .regReq(regReq), .rdData(rdData), .extIrqPinA(extIrqPinA),
   .ovfAckA(ovfAckA), .extAckA(extAckA), .ovfFlagA(ovfFlagA), .ovfFlagB(ovfFlagB),
   .extFlagA(extFlagA), .extFlagB(extFlagB));
`default_nettype wire

// >>> verif/dtc_pin_model.sv
// Behavioural source for the external count pin of unit A.
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model #(
   parameter int HALF = 6
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic goA,
   output logic countPinA,
   output int edgesA
);
   int phase;
   // Each level lasts one machine cycle, the fastest legal source; a started period ends high.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         phase <= 0;
         countPinA <= 1'b1;
         edgesA <= 0;
      end else if (phase != 0 || goA) begin
         phase <= (phase == 2 * HALF - 1) ? 0 : phase + 1;
         if (phase == HALF - 1) begin
            countPinA <= 1'b0;
            edgesA <= edgesA + 1;
         end
         if (phase == 2 * HALF - 1) begin
            countPinA <= 1'b1;
         end
      end
   end
endmodule : dtc_pin_model
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking testbench for the timer/counter pair.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dtc_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic clkEn = 1'b1;
   logic extIrqPinA = 1'b1;
   logic goA = 1'b0;
   logic rdValid = 1'b0;
   logic ovfAckA = 1'b0, ovfAckB = 1'b0, extAckA = 1'b0;
   logic countPinA, ovfFlagA, ovfFlagB, extFlagA, extFlagB;
   logic [7:0] rdData;
   logic [15:0] lfsrState = 16'hB99B;
   logic [7:0] expQ[$];
   dtc_req_s regReq = '0;
   int edgesA;
   int errors = 0;
   int tests_run = 0;
   always #25 sys_clk = ~sys_clk;
   dtc_timer_pair dtc_timer_pair_inst (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
      .regReq(regReq), .rdData(rdData), .countPinA(countPinA), .countPinB(1'b1),
      .extIrqPinA(extIrqPinA), .extIrqPinB(1'b1), .ovfAckA(ovfAckA), .ovfAckB(ovfAckB),
      .extAckA(extAckA), .extAckB(1'b0), .ovfFlagA(ovfFlagA), .ovfFlagB(ovfFlagB),
      .extFlagA(extFlagA), .extFlagB(extFlagB));
   dtc_pin_model dtc_pin_model_inst (.sys_clk(sys_clk), .rst(rst), .goA(goA),
      .countPinA(countPinA), .edgesA(edgesA));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regReq.addr <= a;
      regReq.wrData <= d;
      regReq.wrStb <= 1'b1;
      @(posedge sys_clk);
      regReq.wrStb <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      regReq.addr <= a;
      regReq.rdStb <= 1'b1;
      expQ.push_back(e);
      @(posedge sys_clk);
      regReq.rdStb <= 1'b0;
   endtask : rd
   task automatic bw(input logic [7:0] a, input int i, input logic v);
      @(posedge sys_clk);
      regReq.addr <= a;
      regReq.bitIdx <= 3'(i);
      regReq.bitVal <= v;
      regReq.bitWrStb <= 1'b1;
      @(posedge sys_clk);
      regReq.bitWrStb <= 1'b0;
   endtask : bw
   // Run bit is high for exactly 60 edges, so any divider phase yields ten ticks.
   task automatic runFor(input int i);
      bw(CTRL_OFFSET, i, 1'b1);
      repeat (58) @(posedge sys_clk);
      bw(CTRL_OFFSET, i, 1'b0);
   endtask : runFor
   task automatic setA(input logic [7:0] l, input logic [7:0] h);
      wr(LOW_A_OFFSET, l);
      wr(HIGH_A_OFFSET, h);
   endtask : setA
   task automatic ack(input logic [2:0] m);
      @(posedge sys_clk);
      {ovfAckA, ovfAckB, extAckA} <= m;
      @(posedge sys_clk);
      {ovfAckA, ovfAckB, extAckA} <= 3'h0;
      @(negedge sys_clk);
   endtask : ack
   always @(posedge sys_clk) rdValid <= regReq.rdStb && clkEn;
   always @(negedge sys_clk) begin
      if (rdValid) begin
         check(rdData, expQ.pop_front());
      end
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      tally_and_finish();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      rd(MODE_OFFSET, MODE_RESET);
      rd(CTRL_OFFSET, CTRL_RESET);
      rd(8'h90, 8'h00);
      lfsrState = lfsr(lfsrState);
      wr(MODE_OFFSET, lfsrState[7:0]);
      bw(MODE_OFFSET, 0, ~lfsrState[0]);
      rd(MODE_OFFSET, lfsrState[7:0]);
      wr(MODE_OFFSET, 8'h01);
      setA(8'hFE, 8'hFF);
      runFor(RUN_A_BIT);
      rd(LOW_A_OFFSET, 8'h08);
      rd(HIGH_A_OFFSET, 8'h00);
      check({7'h0, ovfFlagA}, 8'h01);
      bw(CTRL_OFFSET, OVF_A_BIT, 1'b0);
      @(negedge sys_clk);
      check({7'h0, ovfFlagA}, 8'h00);
      // Thirty enabled edges with the run bit high give five ticks; frozen edges give none.
      setA(8'h00, 8'h00);
      bw(CTRL_OFFSET, RUN_A_BIT, 1'b1);
      repeat (10) @(posedge sys_clk);
      clkEn <= 1'b0;
      repeat (30) @(posedge sys_clk);
      clkEn <= 1'b1;
      repeat (18) @(posedge sys_clk);
      bw(CTRL_OFFSET, RUN_A_BIT, 1'b0);
      rd(LOW_A_OFFSET, 8'h05);
      wr(MODE_OFFSET, 8'h00);
      setA(8'hFE, 8'hFF);
      runFor(RUN_A_BIT);
      rd(LOW_A_OFFSET, 8'hE8);
      rd(HIGH_A_OFFSET, 8'h00);
      check({7'h0, ovfFlagA}, 8'h01);
      ack(3'h4);
      check({7'h0, ovfFlagA}, 8'h00);
      wr(MODE_OFFSET, 8'h02);
      setA(8'hFC, 8'hF8);
      runFor(RUN_A_BIT);
      rd(LOW_A_OFFSET, 8'hFE);
      rd(HIGH_A_OFFSET, 8'hF8);
      check({7'h0, ovfFlagA}, 8'h01);
      ack(3'h4);
      wr(MODE_OFFSET, 8'h33);
      setA(8'h00, 8'hFC);
      wr(LOW_B_OFFSET, 8'h55);
      runFor(RUN_B_BIT);
      rd(HIGH_A_OFFSET, 8'h06);
      rd(LOW_A_OFFSET, 8'h00);
      rd(LOW_B_OFFSET, 8'h55);
      check({6'h0, ovfFlagB, ovfFlagA}, 8'h02);
      ack(3'h2);
      wr(MODE_OFFSET, 8'h10);
      wr(LOW_B_OFFSET, 8'hFE);
      wr(HIGH_B_OFFSET, 8'hFF);
      runFor(RUN_B_BIT);
      rd(LOW_B_OFFSET, 8'h08);
      rd(HIGH_B_OFFSET, 8'h00);
      check({6'h0, ovfFlagB, ovfFlagA}, 8'h02);
      ack(3'h2);
      wr(MODE_OFFSET, 8'h05);
      setA(8'h00, 8'h00);
      bw(CTRL_OFFSET, RUN_A_BIT, 1'b1);
      rd(CTRL_OFFSET, 8'h10);
      goA <= 1'b1;
      repeat (120) @(posedge sys_clk);
      goA <= 1'b0;
      repeat (40) @(posedge sys_clk);
      bw(CTRL_OFFSET, RUN_A_BIT, 1'b0);
      rd(LOW_A_OFFSET, edgesA[7:0]);
      bw(CTRL_OFFSET, EXT_TYPE_A_BIT, 1'b1);
      extIrqPinA <= 1'b0;
      for (int i = 0; i < 20 && extFlagA !== 1'b1; i++) @(posedge sys_clk);
      @(negedge sys_clk);
      check({7'h0, extFlagA}, 8'h01);
      ack(3'h1);
      repeat (20) @(posedge sys_clk);
      @(negedge sys_clk);
      check({7'h0, extFlagA}, 8'h00);
      bw(CTRL_OFFSET, EXT_TYPE_A_BIT, 1'b0);
      repeat (20) @(posedge sys_clk);
      @(negedge sys_clk);
      check({7'h0, extFlagA}, 8'h01);
      wr(MODE_OFFSET, 8'h09);
      setA(8'h00, 8'h00);
      runFor(RUN_A_BIT);
      rd(LOW_A_OFFSET, 8'h00);
      extIrqPinA <= 1'b1;
      repeat (20) @(posedge sys_clk);
      runFor(RUN_A_BIT);
      rd(LOW_A_OFFSET, 8'h0A);
      // A second reset with both units stopped must clear the mode byte and the still-set external flag.
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      rd(MODE_OFFSET, MODE_RESET);
      rd(CTRL_OFFSET, CTRL_RESET);
      repeat (3) @(posedge sys_clk);
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
